// *** design/packer_pkg.sv ***
/*
  Constants, field layouts and types shared by the serial-to-network
  packer and its test bench.
  Assumes a 250 MHz mclk; the ms prescale count is derived from that here.
*/
`default_nettype none

package packer_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_MS = 1000;

  // ***************************************************************
  // buffer geometry and field values
  // ***************************************************************
  localparam int unsigned DEPTH = 256;
  localparam int unsigned AW = 8;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [8:0] CNT_FULL = 9'h100;
  localparam logic [AW-1:0] PTR_ZERO = 8'h00;
  localparam logic [AW-1:0] PTR_ONE = 8'h01;
  localparam logic [15:0] T_OFF = 16'h0000;
  localparam logic [15:0] T_ONE = 16'h0001;
  localparam logic [15:0] T_MAX = 16'hFFFF;
  localparam logic [7:0] B_OFF = 8'h00;
  localparam logic [2:0] IDX_ZERO = 3'h0;
  localparam logic [2:0] IDX_ONE = 3'h1;
  localparam logic [3:0] PW_NONE = 4'h0;

  // ***************************************************************
  // debug message codes
  // ***************************************************************
  localparam logic [2:0] DBG_NONE = 3'h0;
  localparam logic [2:0] DBG_LISTEN = 3'h1;
  localparam logic [2:0] DBG_CONNECT = 3'h2;
  localparam logic [2:0] DBG_CONN_FAIL = 3'h3;
  localparam logic [2:0] DBG_AUTH_FAIL = 3'h4;
  localparam logic [2:0] DBG_IDLE_CLOSE = 3'h5;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_AUTH = 2'b01,
    ST_OPEN = 2'b10
  } sess_state_t;

  typedef struct packed {
    logic [15:0] time_ms;
    logic [7:0] size;
    logic [7:0] delim;
  } pack_cfg_t;

  typedef struct packed {
    logic server;
    logic pw_en;
    logic [3:0] pw_len;
    logic [63:0] pw;
    logic [15:0] idle_s;
    logic ka_en;
    logic [15:0] ka_ms;
    logic dbg_en;
  } sess_cfg_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } entry_t;

endpackage

`default_nettype wire

// *** design/serial_to_net_packer.sv ***
/*
  Serial-to-network packer with session control: byte buffer with
  idle/size/delimiter packing, inactivity close, connection password,
  keep-alive, serial command mode gate and debug events.
  Assumes the network stack and UART are outside, all synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_to_net_packer
  import packer_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clr,
  input wire pack_cfg_t pack_cfg,
  input wire sess_cfg_t sess_cfg,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic pkt_ready,
  input wire logic conn_req,
  input wire logic conn_fail,
  input wire logic close_req,
  input wire logic net_rx_valid,
  input wire logic pw_valid,
  input wire logic [7:0] pw_byte,
  input wire logic ka_reply,
  input wire logic defaults_apply,
  input wire logic cmd_enable_set,
  input wire logic cmd_enter_req,
  input wire logic cmd_exit_req,
  output logic pkt_valid_q,
  output entry_t pkt_q,
  output logic rx_overrun_q,
  output logic conn_open_q,
  output logic conn_refuse_q,
  output logic conn_close_q,
  output logic ka_send_q,
  output logic cmd_enable_q,
  output logic cmd_mode_q,
  output logic dbg_valid_q,
  output logic [2:0] dbg_code_q
);

  // ***************************************************************
  // ticks
  // ***************************************************************
  logic ms_tick;
  logic sec_tick;

  tick_div #(.DIV(MS_DIV)) u_ms_div (
    .mclk(mclk),
    .resetn(resetn),
    .clr(clr),
    .en(1'b1),
    .tick_q(ms_tick)
  );

  tick_div #(.DIV(SEC_MS)) u_sec_div (
    .mclk(mclk),
    .resetn(resetn),
    .clr(clr),
    .en(ms_tick),
    .tick_q(sec_tick)
  );

  // ***************************************************************
  // buffer and packing
  // ***************************************************************
  entry_t mem_q [DEPTH];
  entry_t mem_d [DEPTH];
  logic [AW-1:0] head_q, head_d, tail_q, tail_d;
  logic [8:0] cnt_q, cnt_d, sealed_q, sealed_d, unsealed;
  logic [15:0] idle_ms_q, idle_ms_d;
  logic pkt_valid_d, overrun_d;
  entry_t pkt_d;
  logic wr, pop, all_off, size_hit, delim_hit, raw_hit, full_hit;
  logic idle_hit, fire;

  // raw bytes only: no protocol escaping anywhere on this path
  always_comb
  begin
    mem_d = mem_q;
    wr = rx_valid && (cnt_q != CNT_FULL) && !clr;
    overrun_d = rx_valid && (cnt_q == CNT_FULL);
    pop = (sealed_q != CNT_ZERO) && (!pkt_valid_q || pkt_ready) && !clr;
    unsealed = cnt_q - sealed_q;
    all_off = (pack_cfg.time_ms == T_OFF) && (pack_cfg.size == B_OFF)
      && (pack_cfg.delim == B_OFF);
    size_hit = wr && (pack_cfg.size != B_OFF)
      && (unsealed + CNT_ONE == {1'b0, pack_cfg.size});
    delim_hit = wr && (pack_cfg.delim != B_OFF)
      && (rx_byte == pack_cfg.delim);
    raw_hit = wr && all_off;
    // a full buffer with nothing sealed would stall forever, so seal it
    full_hit = wr && (cnt_q + CNT_ONE == CNT_FULL);
    idle_hit = !wr && (pack_cfg.time_ms != T_OFF)
      && (unsealed != CNT_ZERO) && (idle_ms_q >= pack_cfg.time_ms);
    fire = size_hit || delim_hit || raw_hit || full_hit || idle_hit;
    cnt_d = cnt_q + {8'h00, wr} - {8'h00, pop};
    head_d = head_q + (pop ? PTR_ONE : PTR_ZERO);
    tail_d = tail_q + (wr ? PTR_ONE : PTR_ZERO);
    if (wr)
    begin
      mem_d[tail_q] = '{last: fire, data: rx_byte};
    end
    if (idle_hit)
    begin
      mem_d[tail_q - PTR_ONE].last = 1'b1;
    end
    // later bytes sit beyond the seal and open the next packet
    sealed_d = fire ? cnt_d : sealed_q - {8'h00, pop};
    pkt_d = pkt_q;
    pkt_valid_d = pkt_valid_q && !pkt_ready;
    if (pop)
    begin
      pkt_d = mem_q[head_q];
      pkt_valid_d = 1'b1;
    end
    idle_ms_d = idle_ms_q;
    if (wr)
    begin
      idle_ms_d = T_OFF;
    end
    else if (ms_tick && idle_ms_q != T_MAX)
    begin
      idle_ms_d = idle_ms_q + T_ONE;
    end
    if (clr)
    begin
      head_d = PTR_ZERO;
      tail_d = PTR_ZERO;
      cnt_d = CNT_ZERO;
      sealed_d = CNT_ZERO;
      idle_ms_d = T_OFF;
      pkt_valid_d = 1'b0;
      overrun_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_q <= '{default: '0};
      head_q <= '0;
      tail_q <= '0;
      cnt_q <= '0;
      sealed_q <= '0;
      idle_ms_q <= '0;
      pkt_valid_q <= 1'b0;
      pkt_q <= '0;
      rx_overrun_q <= 1'b0;
    end
    else
    begin
      mem_q <= mem_d;
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q <= cnt_d;
      sealed_q <= sealed_d;
      idle_ms_q <= idle_ms_d;
      pkt_valid_q <= pkt_valid_d;
      pkt_q <= pkt_d;
      rx_overrun_q <= overrun_d;
    end
  end

  // ***************************************************************
  // session
  // ***************************************************************
  sess_state_t state_q, state_d;
  logic [2:0] pw_idx_q, pw_idx_d;
  logic [15:0] idle_s_q, idle_s_d, ka_cnt_q, ka_cnt_d;
  logic refuse_d, close_d, ka_d, open_d, ev, dbg_v_d;
  logic [2:0] code, dbg_c_d;
  logic cmd_en_d, cmd_mode_d, activity, need_pw;

  always_comb
  begin
    state_d = state_q;
    pw_idx_d = pw_idx_q;
    refuse_d = conn_req && (state_q != ST_WAIT);
    close_d = 1'b0;
    ka_d = 1'b0;
    code = DBG_NONE;
    activity = wr || net_rx_valid || (pkt_valid_q && pkt_ready);
    need_pw = sess_cfg.server && sess_cfg.pw_en
      && (sess_cfg.pw_len != PW_NONE);
    case (state_q)
      ST_WAIT:
      begin
        if (conn_req)
        begin
          pw_idx_d = IDX_ZERO;
          state_d = need_pw ? ST_AUTH : ST_OPEN;
          code = need_pw ? DBG_NONE : DBG_CONNECT;
        end
        else if (conn_fail)
        begin
          code = DBG_CONN_FAIL;
        end
      end
      ST_AUTH:
      begin
        // no data counts until the client has sent the password
        if (close_req)
        begin
          state_d = ST_WAIT;
          code = DBG_LISTEN;
        end
        else if (pw_valid)
        begin
          if (pw_byte != sess_cfg.pw[{pw_idx_q, 3'h0} +: 8])
          begin
            state_d = ST_WAIT;
            close_d = 1'b1;
            code = DBG_AUTH_FAIL;
          end
          else if ({1'b0, pw_idx_q} + 4'h1 == sess_cfg.pw_len)
          begin
            state_d = ST_OPEN;
            code = DBG_CONNECT;
          end
          else
          begin
            pw_idx_d = pw_idx_q + IDX_ONE;
          end
        end
      end
      ST_OPEN:
      begin
        if (close_req)
        begin
          state_d = ST_WAIT;
          code = DBG_LISTEN;
        end
        else if (sess_cfg.idle_s != T_OFF && idle_s_q >= sess_cfg.idle_s)
        begin
          state_d = ST_WAIT;
          close_d = 1'b1;
          code = DBG_IDLE_CLOSE;
        end
        else if (sess_cfg.ka_en && sess_cfg.ka_ms != T_OFF
          && ka_cnt_q >= sess_cfg.ka_ms)
        begin
          ka_d = 1'b1;
        end
      end
      default:
      begin
        state_d = ST_WAIT;
      end
    endcase
    idle_s_d = idle_s_q;
    if (activity || state_q != ST_OPEN)
    begin
      idle_s_d = T_OFF;
    end
    else if (sec_tick && idle_s_q != T_MAX)
    begin
      idle_s_d = idle_s_q + T_ONE;
    end
    ka_cnt_d = ka_cnt_q;
    if (ka_reply || ka_d || state_q != ST_OPEN)
    begin
      ka_cnt_d = T_OFF;
    end
    else if (ms_tick && ka_cnt_q != T_MAX)
    begin
      ka_cnt_d = ka_cnt_q + T_ONE;
    end
    ev = code != DBG_NONE;
    dbg_v_d = ev && sess_cfg.dbg_en;
    dbg_c_d = ev ? code : dbg_code_q;
    cmd_en_d = defaults_apply ? 1'b0 : (cmd_enable_q || cmd_enable_set);
    cmd_mode_d = cmd_mode_q;
    if (defaults_apply || !cmd_enable_q)
    begin
      cmd_mode_d = 1'b0;
    end
    else if (cmd_enter_req)
    begin
      cmd_mode_d = 1'b1;
    end
    else if (cmd_exit_req)
    begin
      cmd_mode_d = 1'b0;
    end
    if (clr)
    begin
      state_d = ST_WAIT;
      idle_s_d = T_OFF;
      ka_cnt_d = T_OFF;
      refuse_d = 1'b0;
      close_d = 1'b0;
      ka_d = 1'b0;
      dbg_v_d = 1'b0;
    end
    open_d = state_d == ST_OPEN;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_WAIT;
      pw_idx_q <= '0;
      idle_s_q <= '0;
      ka_cnt_q <= '0;
      conn_open_q <= 1'b0;
      conn_refuse_q <= 1'b0;
      conn_close_q <= 1'b0;
      ka_send_q <= 1'b0;
      cmd_enable_q <= 1'b0;
      cmd_mode_q <= 1'b0;
      dbg_valid_q <= 1'b0;
      dbg_code_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      pw_idx_q <= pw_idx_d;
      idle_s_q <= idle_s_d;
      ka_cnt_q <= ka_cnt_d;
      conn_open_q <= open_d;
      conn_refuse_q <= refuse_d;
      conn_close_q <= close_d;
      ka_send_q <= ka_d;
      cmd_enable_q <= cmd_en_d;
      cmd_mode_q <= cmd_mode_d;
      dbg_valid_q <= dbg_v_d;
      dbg_code_q <= dbg_c_d;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  idle_restart_a: assert property (wr |=> idle_ms_q == T_OFF)
    else $error("byte did not restart idle timer");
  size_seal_a: assert property (size_hit |=> sealed_q == cnt_q)
    else $error("size hit did not seal buffer");
  delim_mark_a: assert property (delim_hit ##1 !clr
    |-> mem_q[$past(tail_q)].last)
    else $error("delimiter byte not marked as packet end");
  raw_fwd_a: assert property (raw_hit ##1 !clr
    |-> mem_q[$past(tail_q)].last && sealed_q == cnt_q)
    else $error("byte not forwarded with conditions off");
  idle_close_a: assert property (state_q == ST_OPEN && !clr && !close_req
    && sess_cfg.idle_s != T_OFF && idle_s_q >= sess_cfg.idle_s
    |=> state_q == ST_WAIT && conn_close_q)
    else $error("inactivity close missed");
  no_close_a: assert property (state_q == ST_OPEN && !clr && !close_req
    && sess_cfg.idle_s == T_OFF |=> conn_open_q)
    else $error("connection dropped with inactivity off");
  refuse_peer_a: assert property (conn_req && state_q != ST_WAIT && !clr
    |=> conn_refuse_q && $stable(state_q) or state_q == ST_WAIT)
    else $error("second peer not refused");
  pw_skip_a: assert property (state_q == ST_WAIT && conn_req && !clr
    && !(sess_cfg.server && sess_cfg.pw_en) |=> conn_open_q)
    else $error("password check not skipped");
  ka_send_a: assert property (ka_send_q |-> $past(ka_cnt_q)
    >= $past(sess_cfg.ka_ms) && $past(sess_cfg.ka_en))
    else $error("keep-alive sent early");
  cmd_gate_a: assert property (!cmd_enable_q |=> !cmd_mode_q)
    else $error("command mode entered while disabled");
  dbg_gate_a: assert property (dbg_valid_q |-> $past(sess_cfg.dbg_en))
    else $error("debug event with debug off");

endmodule

`default_nettype wire

// *** design/tick_div.sv ***
/*
  Prescaler: one-cycle tick every DIV enabled cycles.
  Assumes DIV of at least 2 and a clr that is synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tick_div
#(
  parameter int unsigned DIV = 2
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic en,
  output logic tick_q
);

  localparam int unsigned W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] ZERO = '0;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_d;

  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (clr)
    begin
      cnt_d = ZERO;
    end
    else if (en)
    begin
      if (cnt_q == LAST)
      begin
        cnt_d = ZERO;
        tick_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule

`default_nettype wire

// *** test/net_sink.sv ***
/*
  Network-side partner of the packer: takes packet bytes, either at
  once or stalling every other cycle.
  Assumes pkt_valid_q and pkt_q stand until taken, all on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module net_sink
  import packer_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic pkt_valid_q,
  input wire entry_t pkt_q,
  output logic pkt_ready
);
  // ***************************************************************
  // sink
  // ***************************************************************
  entry_t got[$];
  logic ph_q;

  // stalling shows whether the block holds a byte until it is taken
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ph_q <= 1'b0;
    end
    else
    begin
      ph_q <= ~ph_q;
      if (pkt_valid_q === 1'b1 && pkt_ready)
      begin
        got.push_back(pkt_q);
      end
    end
  end

  assign pkt_ready = !slow || ph_q;
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
/*
  Self-checking bench for the serial-to-network packer.
  Assumes the packer top and package, and net_sink as network partner.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import packer_pkg::*;
  // ***************************************************************
  // harness
  // ***************************************************************
  // short ms prescale keeps the one-second inactivity test affordable
  localparam int unsigned DIV = 8;
  logic mclk, resetn, clr, rx_valid, pkt_ready, conn_req, conn_fail;
  logic close_req, net_rx_valid, pw_valid, ka_reply, defaults_apply;
  logic cmd_enable_set, cmd_enter_req, cmd_exit_req, slow;
  logic [7:0] rx_byte, pw_byte;
  pack_cfg_t pack_cfg;
  sess_cfg_t sess_cfg, c;
  logic pkt_valid_q, rx_overrun_q, conn_open_q, conn_refuse_q;
  logic conn_close_q, ka_send_q, cmd_enable_q, cmd_mode_q, dbg_valid_q;
  logic [2:0] dbg_code_q;
  entry_t pkt_q;
  entry_t exp_q[$];
  int num_errors = 0, comparisons = 0, n_ref = 0, n_cls = 0, n_ka = 0;
  int n_dbg = 0;
  int n, k;

  serial_to_net_packer #(.MS_DIV(DIV)) DUT (.mclk(mclk), .resetn(resetn),
    .clr(clr), .pack_cfg(pack_cfg), .sess_cfg(sess_cfg),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .pkt_ready(pkt_ready),
    .conn_req(conn_req), .conn_fail(conn_fail), .close_req(close_req),
    .net_rx_valid(net_rx_valid), .pw_valid(pw_valid), .pw_byte(pw_byte),
    .ka_reply(ka_reply), .defaults_apply(defaults_apply),
    .cmd_enable_set(cmd_enable_set), .cmd_enter_req(cmd_enter_req),
    .cmd_exit_req(cmd_exit_req), .pkt_valid_q(pkt_valid_q), .pkt_q(pkt_q),
    .rx_overrun_q(rx_overrun_q), .conn_open_q(conn_open_q),
    .conn_refuse_q(conn_refuse_q), .conn_close_q(conn_close_q),
    .ka_send_q(ka_send_q), .cmd_enable_q(cmd_enable_q),
    .cmd_mode_q(cmd_mode_q), .dbg_valid_q(dbg_valid_q),
    .dbg_code_q(dbg_code_q));

  net_sink net (.mclk(mclk), .resetn(resetn), .slow(slow),
    .pkt_valid_q(pkt_valid_q), .pkt_q(pkt_q), .pkt_ready(pkt_ready));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // pulses are counted so their exact cycle does not matter to checks
  always @(posedge mclk)
  begin
    if (conn_refuse_q === 1'b1) n_ref++;
    if (conn_close_q === 1'b1) n_cls++;
    if (ka_send_q === 1'b1) n_ka++;
    if (dbg_valid_q === 1'b1) n_dbg++;
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int i);
    repeat (i) @(posedge mclk);
  endtask

  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      rx_valid <= 1'b1;
      rx_byte <= s[i];
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
  endtask

  task automatic pw_send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      pw_valid <= 1'b1;
      pw_byte <= s[i];
      @(posedge mclk);
    end
    pw_valid <= 1'b0;
  endtask

  // expected packet: the final byte carries the end mark
  task automatic push(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      exp_q.push_back({i == s.len() - 1, s[i]});
    end
  endtask

  task automatic drain(input int lim);
    int w;
    w = 0;
    while (net.got.size() < exp_q.size() && w < lim)
    begin
      @(posedge mclk);
      w++;
    end
    chk(net.got.size() == exp_q.size(), "packet length");
    for (int i = 0; i < exp_q.size() && i < net.got.size(); i++)
    begin
      chk(net.got[i] === exp_q[i], "packet byte");
    end
    net.got.delete();
    exp_q.delete();
  endtask

  task automatic conn;
    conn_req <= 1'b1;
    @(posedge mclk);
    conn_req <= 1'b0;
    cyc(2);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_size_delim;
    slow <= 1'b1;
    pack_cfg <= {T_OFF, 8'h0A, 8'h0D};
    @(posedge mclk);
    send("0123456789abc");
    push("0123456789");
    drain(80);
    cyc(30);
    chk(net.got.size() == 0, "tail sent early");
    send("\015");
    push("abc\015");
    drain(80);
    slow <= 1'b0;
  endtask

  task automatic t_idle;
    send("mn");
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    pack_cfg <= {16'h0002, B_OFF, B_OFF};
    cyc(2);
    send("xy");
    cyc(5);
    chk(net.got.size() == 0, "idle fired early");
    send("z");
    cyc(5);
    chk(net.got.size() == 0, "idle not restarted");
    push("xyz");
    drain(60);
  endtask

  task automatic t_all_off;
    pack_cfg <= '0;
    @(posedge mclk);
    send("pq");
    push("p");
    push("q");
    drain(20);
  endtask

  task automatic t_session;
    c = '0;
    c.dbg_en = 1'b1;
    c.idle_s = T_ONE;
    sess_cfg <= c;
    conn_fail <= 1'b1;
    @(posedge mclk);
    conn_fail <= 1'b0;
    cyc(2);
    chk(dbg_code_q === DBG_CONN_FAIL, "debug code");
    conn();
    chk(conn_open_q === 1'b1, "not open");
    chk(dbg_code_q === DBG_CONNECT, "debug code");
    n = n_ref;
    conn();
    chk(n_ref == n + 1 && conn_open_q === 1'b1, "second peer");
    n = n_cls;
    k = 0;
    while (n_cls == n && k < 9000)
    begin
      @(posedge mclk);
      k++;
    end
    cyc(2);
    chk(n_cls == n + 1 && conn_open_q === 1'b0, "no idle close");
    chk(dbg_code_q === DBG_IDLE_CLOSE, "debug code");
    chk(n_dbg == 3, "debug pulse count");
    conn();
    chk(conn_open_q === 1'b1, "no reopen");
    c.idle_s = T_OFF;
    sess_cfg <= c;
    cyc(9000);
    chk(conn_open_q === 1'b1, "closed while off");
    n = n_cls;
    close_req <= 1'b1;
    @(posedge mclk);
    close_req <= 1'b0;
    cyc(2);
    chk(conn_open_q === 1'b0 && n_cls == n, "explicit close");
  endtask

  task automatic t_pw;
    c.server = 1'b1;
    c.pw_en = 1'b1;
    c.pw_len = 4'h2;
    c.pw[15:0] = 16'h4261;
    sess_cfg <= c;
    @(posedge mclk);
    conn();
    chk(conn_open_q === 1'b0, "open without password");
    n = n_cls;
    pw_send("ab");
    cyc(2);
    chk(n_cls == n + 1 && conn_open_q === 1'b0, "case ignored");
    conn();
    pw_send("aB");
    cyc(2);
    chk(conn_open_q === 1'b1, "password refused");
    close_req <= 1'b1;
    @(posedge mclk);
    close_req <= 1'b0;
    c.server = 1'b0;
    sess_cfg <= c;
    cyc(2);
    conn();
    chk(conn_open_q === 1'b1, "check as client");
  endtask

  task automatic t_ka;
    c.ka_en = 1'b1;
    c.ka_ms = 16'h0003;
    sess_cfg <= c;
    cyc(2);
    repeat (10)
    begin
      ka_reply <= 1'b1;
      @(posedge mclk);
      ka_reply <= 1'b0;
      cyc(7);
      if (k == 0) n = n_ka;
      k = 1;
    end
    chk(n_ka == n, "keep-alive despite reply");
    cyc(60);
    chk(n_ka > n, "no keep-alive");
  endtask

  task automatic t_cmd;
    defaults_apply <= 1'b1;
    @(posedge mclk);
    defaults_apply <= 1'b0;
    cmd_enter_req <= 1'b1;
    @(posedge mclk);
    cmd_enter_req <= 1'b0;
    cyc(2);
    chk(cmd_mode_q === 1'b0 && cmd_enable_q === 1'b0, "entered");
    cmd_enable_set <= 1'b1;
    @(posedge mclk);
    cmd_enable_set <= 1'b0;
    @(posedge mclk);
    cmd_enter_req <= 1'b1;
    @(posedge mclk);
    cmd_enter_req <= 1'b0;
    cyc(2);
    chk(cmd_mode_q === 1'b1, "not entered");
    cmd_exit_req <= 1'b1;
    @(posedge mclk);
    cmd_exit_req <= 1'b0;
    cyc(2);
    chk(cmd_mode_q === 1'b0, "not left");
  endtask

  // ***************************************************************
  // run control
  // ***************************************************************
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial
  begin
    {resetn, clr, rx_valid, conn_req, conn_fail, close_req} = '0;
    {net_rx_valid, pw_valid, ka_reply, defaults_apply, slow} = '0;
    {cmd_enable_set, cmd_enter_req, cmd_exit_req, rx_byte, pw_byte} = '0;
    pack_cfg = '0;
    sess_cfg = '0;
    k = 0;
    cyc(12);
    resetn <= 1'b1;
    @(posedge mclk);
    t_size_delim();
    t_idle();
    t_all_off();
    t_session();
    k = 0;
    t_pw();
    t_ka();
    t_cmd();
    test_done();
  end

  initial
  begin
    cyc(60000);
    num_errors++;
    test_done();
  end
endmodule

`default_nettype wire
